/* shared/ueb_cfg.svh */
// offsets, field positions, reset values and timing counts of the endpoint buffer block
`ifndef UEB_CFG_SVH
`define UEB_CFG_SVH
// register offsets (9-bit firmware address)
`define UEB_A_CTRL     9'h000
`define UEB_A_IFLAG    9'h001
`define UEB_A_IEN      9'h002
`define UEB_A_XSTAT    9'h003
`define UEB_A_EPCTL0   9'h004
`define UEB_A_EPCTL1   9'h005
`define UEB_A_BD_BASE  9'h010
`define UEB_A_BD_MASK  9'h1F0
`define UEB_A_RAM_LO   9'h1B8
`define UEB_A_RAM_HI   9'h1DF
// sizes
`define UEB_RAM_WORDS  40
`define UEB_NUM_BD     4
// control register bits
`define UEB_CTRL_ATTACH 0
`define UEB_CTRL_IDLE   1
`define UEB_CTRL_SUSP   2
// interrupt flag and enable bits
`define UEB_F_TOK      0
`define UEB_F_ERR      1
`define UEB_F_ACT      2
`define UEB_F_RST      3
// endpoint control bits
`define UEB_EP_STALL   0
`define UEB_EP_EN      1
// descriptor status bits
`define UEB_BD_OWN     7
`define UEB_BD_DATA1   6
`define UEB_BD_SETUP   2
// transfer status fields
`define UEB_XS_EP      4
`define UEB_XS_DIR     3
`define UEB_XS_SETUP   2
// reset values
`define UEB_RST_BYTE   8'h00
// timing
`define UEB_CLK_KHZ    20000
`define UEB_IDLE_MS    3
`define UEB_IDLE_CYC   (`UEB_IDLE_MS * `UEB_CLK_KHZ)
`endif

/* shared/ueb_pkg.sv */
// types of the endpoint buffer block
package ueb_pkg;
`include "ueb_cfg.svh"

   typedef enum logic [3:0] {
      ENG_IDLE = 4'b0001,
      ENG_RX   = 4'b0010,
      ENG_TX   = 4'b0100,
      ENG_HS   = 4'b1000
   } ueb_eng_e;

   typedef enum logic [1:0] {
      PID_OUT   = 2'h0,
      PID_IN    = 2'h1,
      PID_SETUP = 2'h2
   } ueb_pid_e;

   typedef enum logic [1:0] {
      HS_ACK   = 2'h0,
      HS_NAK   = 2'h1,
      HS_STALL = 2'h2
   } ueb_hs_e;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } ueb_reg_req_s;

   typedef struct packed {
      ueb_pid_e   pid;
      logic [3:0] ep;
   } ueb_tok_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       done;
      logic       crc_err;
   } ueb_rx_s;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
      logic       empty;
      logic       data1;
   } ueb_tx_s;

   typedef struct packed {
      ueb_eng_e        st;
      ueb_hs_e         hs;
      logic            attach;
      logic            idle;
      logic            susp;
      logic            irq;
      logic [3:0]      iflag;
      logic [3:0]      ien;
      logic [7:0]      xstat;
      logic [1:0]      stall;
      logic [1:0]      ep_en;
      logic [3:0][7:0] bd_stat;
      logic [3:0][7:0] bd_cnt;
      logic [3:0][7:0] bd_addr;
      logic [1:0]      cur;
      logic [5:0]      idx;
      logic            is_setup;
      logic            drop;
      logic            bad;
      logic            tx_ph;
      logic [15:0]     idle_cnt;
      logic [1:0]      act_sync;
      logic            act_prev;
      logic [1:0]      rst_sync;
      logic            rst_prev;
      logic [7:0]      rdata;
      logic            rd_ram;
   } ueb_state_s;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
   } ueb_ram_rd_s;
endpackage

/* rtl/ueb_dpram.sv */
// dual-port buffer memory: firmware port a, engine port b
`timescale 1ns/1ps
module ueb_dpram (
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // firmware port
   input  wire logic [5:0] a_addr,
   input  wire logic       a_we,
   input  wire logic [7:0] a_wdata,
   output logic      [7:0] a_rdata,
   // engine port
   input  wire logic [5:0] b_addr,
   input  wire logic       b_we,
   input  wire logic [7:0] b_wdata,
   output logic      [7:0] b_rdata
);
   import ueb_pkg::*;

   logic [7:0]  mem [`UEB_RAM_WORDS];
   ueb_ram_rd_s r;
   ueb_ram_rd_s next_r;

   // out-of-range index reads zero
   always_comb begin
      next_r.a = (a_addr < 6'(`UEB_RAM_WORDS)) ? mem[a_addr] : 8'h00;
      next_r.b = (b_addr < 6'(`UEB_RAM_WORDS)) ? mem[b_addr] : 8'h00;
   end

   // storage has no reset, like real cells
   always_ff @(posedge clk) begin
      if (ce && a_we && a_addr < 6'(`UEB_RAM_WORDS)) begin
         mem[a_addr] <= a_wdata;
      end
      if (ce && b_we && b_addr < 6'(`UEB_RAM_WORDS)) begin
         mem[b_addr] <= b_wdata;
      end
   end

   // registered read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign a_rdata = r.a;
   assign b_rdata = r.b;
endmodule

/* rtl/ueb_core.sv */
// endpoint buffer, ownership and bus event logic of a low-speed usb function
// Operation
// [R1] setup data goes to endpoint zero OUT buffer, status recorded, token-done raised
// [R2] firmware fills endpoint zero IN buffer, then sets the owner bit
// [R3] on IN token the engine sends the owned buffer, then raises token-done
// [R4] bus-idle flag sets after 3 ms without bus activity
// [R5] with activity interrupt enabled, first bus transition raises it
// [R6] clearing attach disconnects from the bus; setting it reconnects
// [R7] firmware keeps a soft detach cycle near 50 ms
// [R8] stall bit set makes the endpoint refuse host transfers until cleared
// [R9] bus errors raise the error interrupt; never auto-detach
// [R10] owner bit shows a filled OUT buffer; firmware copies and returns it
// [R11] firmware checks IN buffer free, copies, toggles data bit, sets owner
// [R12] loaded IN buffer stays engine-owned until the host has taken it
// [R13] at start firmware enables regulator and only the bus-reset interrupt
// [R14] on bus reset firmware sets up descriptors, endpoints, other interrupts
// [R15] any enabled interrupt sends the processor to its fixed vector
// [R16] firmware walks powered, default, addressed, configured states
// [R17] after 3 ms idle the block suspends and enables the activity interrupt
// [R18] firmware disables the activity interrupt when servicing wake-up
// [R19] request-type bit 6 set routes token-done to the class handler
// [R20] endpoint zero IN and OUT have own buffers; setup is never refused
// [R21] firmware keeps enumeration state in low bits of a software byte
// [R22] buffer base is eight bits with implied ninth bit, inside 1B8h-1DFh
// [R23] token-done, error and activity flags stay set until firmware clears
`timescale 1ns/1ps
module ueb_core #(
   parameter int IDLE_CYCLES = `UEB_IDLE_CYC
) (
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   // firmware register port
   input  wire ueb_pkg::ueb_reg_req_s reg_req,
   output logic                 [7:0] reg_rdata,
   // token and data path
   input  wire logic                  tok_valid,
   input  wire ueb_pkg::ueb_tok_s     tok,
   input  wire ueb_pkg::ueb_rx_s      rx,
   input  wire logic                  link_err,
   output logic                       tx_valid,
   output ueb_pkg::ueb_tx_s           tx,
   input  wire logic                  tx_ready,
   output logic                       hs_valid,
   output ueb_pkg::ueb_hs_e           hs_code,
   // transceiver pins
   input  wire logic                  line_active,
   input  wire logic                  bus_reset_pin,
   // system outputs
   output logic                       pullup_en,
   output logic                       suspend,
   output logic                       usb_irq
);
   import ueb_pkg::*;

   ueb_state_s s;
   ueb_state_s next_s;
   logic [3:0] set_f;
   logic [3:0] clr_f;
   logic       act_edge;
   logic       rst_edge;
   logic       a_we;
   logic [7:0] a_rdata;
   logic       b_we;
   logic [5:0] b_addr;
   logic [7:0] b_rdata;
   logic [1:0] d;
   logic       ep_ok;

   // address to buffer index
   function automatic logic [5:0] ram_index(input logic [8:0] a);
      logic [8:0] t;
      t = a - `UEB_A_RAM_LO;
      return t[5:0];
   endfunction

   function automatic logic in_ram(input logic [8:0] a);
      return (a >= `UEB_A_RAM_LO) && (a <= `UEB_A_RAM_HI);
   endfunction

   // buffer must fit the shared window; ninth bit implied one
   function automatic logic buf_ok(input logic [7:0] ba, input logic [7:0] len);
      logic [9:0] lo;
      logic [9:0] hi;
      lo = {2'b01, ba};
      hi = lo + {2'b00, len};
      return (lo >= {1'b0, `UEB_A_RAM_LO}) && (hi <= ({1'b0, `UEB_A_RAM_HI} + 10'h001));
   endfunction

   function automatic logic is_bd(input logic [8:0] a);
      return (a & `UEB_A_BD_MASK) == `UEB_A_BD_BASE;
   endfunction

   assign b_addr   = ram_index({1'b1, s.bd_addr[s.cur]} + {3'h0, s.idx}); // [R22]
   assign act_edge = s.act_sync[1] != s.act_prev;
   assign rst_edge = s.rst_sync[1] && !s.rst_prev;
   assign d        = {tok.ep[0], tok.pid == PID_IN};
   assign ep_ok    = (tok.ep < 4'h2) && s.ep_en[tok.ep[0]];

   always_comb begin
      next_s = s;
      set_f  = 4'h0;
      clr_f  = 4'h0;
      a_we   = 1'b0;
      b_we   = 1'b0;

      // pin synchronisers; only the second stage is looked at
      next_s.act_sync = {s.act_sync[0], line_active};
      next_s.act_prev = s.act_sync[1];
      next_s.rst_sync = {s.rst_sync[0], bus_reset_pin};
      next_s.rst_prev = s.rst_sync[1];

      // register read, data presented next cycle
      next_s.rd_ram = reg_req.re && in_ram(reg_req.addr);
      if (reg_req.re) begin
         next_s.rdata = `UEB_RST_BYTE;
         if (reg_req.addr == `UEB_A_CTRL) begin
            next_s.rdata[`UEB_CTRL_ATTACH] = s.attach;
            next_s.rdata[`UEB_CTRL_IDLE]   = s.idle;
            next_s.rdata[`UEB_CTRL_SUSP]   = s.susp;
         end else if (reg_req.addr == `UEB_A_IFLAG) begin
            next_s.rdata[3:0] = s.iflag;
         end else if (reg_req.addr == `UEB_A_IEN) begin
            next_s.rdata[3:0] = s.ien;
         end else if (reg_req.addr == `UEB_A_XSTAT) begin
            next_s.rdata = s.xstat;
         end else if (reg_req.addr == `UEB_A_EPCTL0 || reg_req.addr == `UEB_A_EPCTL1) begin
            next_s.rdata[`UEB_EP_STALL] = s.stall[reg_req.addr[0]];
            next_s.rdata[`UEB_EP_EN]    = s.ep_en[reg_req.addr[0]];
         end else if (is_bd(reg_req.addr)) begin
            unique case (reg_req.addr[1:0])
               2'h0: next_s.rdata = s.bd_stat[reg_req.addr[3:2]];
               2'h1: next_s.rdata = s.bd_cnt[reg_req.addr[3:2]];
               2'h2: next_s.rdata = s.bd_addr[reg_req.addr[3:2]];
               2'h3: next_s.rdata = `UEB_RST_BYTE;
            endcase
         end
      end

      // register write
      if (reg_req.we) begin
         if (reg_req.addr == `UEB_A_CTRL) begin
            next_s.attach = reg_req.wdata[`UEB_CTRL_ATTACH]; // [R6]
         end else if (reg_req.addr == `UEB_A_IFLAG) begin
            clr_f = reg_req.wdata[3:0]; // [R23]
         end else if (reg_req.addr == `UEB_A_IEN) begin
            next_s.ien = reg_req.wdata[3:0];
         end else if (reg_req.addr == `UEB_A_EPCTL0 || reg_req.addr == `UEB_A_EPCTL1) begin
            next_s.stall[reg_req.addr[0]] = reg_req.wdata[`UEB_EP_STALL]; // [R8]
            next_s.ep_en[reg_req.addr[0]] = reg_req.wdata[`UEB_EP_EN];
         end else if (is_bd(reg_req.addr) && !s.bd_stat[reg_req.addr[3:2]][`UEB_BD_OWN]) begin
            // engine-owned descriptors are locked against firmware
            unique case (reg_req.addr[1:0])
               2'h0: next_s.bd_stat[reg_req.addr[3:2]] = reg_req.wdata; // [R10] [R12]
               2'h1: next_s.bd_cnt[reg_req.addr[3:2]]  = reg_req.wdata;
               2'h2: next_s.bd_addr[reg_req.addr[3:2]] = reg_req.wdata;
               2'h3: ;
            endcase
         end else if (in_ram(reg_req.addr)) begin
            a_we = 1'b1;
         end
      end

      // idle timer: any line activity restarts it
      if (s.act_sync[1] || act_edge) begin
         next_s.idle_cnt = 16'h0000;
         next_s.idle     = 1'b0;
      end else if (!s.idle) begin
         if (s.idle_cnt == 16'(IDLE_CYCLES - 1)) begin
            next_s.idle    = 1'b1; // [R4]
            next_s.susp    = 1'b1; // [R17]
            next_s.ien[`UEB_F_ACT] = 1'b1; // [R17]
         end else begin
            next_s.idle_cnt = s.idle_cnt + 16'h0001;
         end
      end

      // wake-up on the first bus transition
      if (act_edge && s.ien[`UEB_F_ACT]) begin
         set_f[`UEB_F_ACT] = 1'b1; // [R5]
         next_s.susp = 1'b0; // [R17]
      end

      // bus errors are only reported, the pull-up stays as firmware left it
      if (link_err) begin
         set_f[`UEB_F_ERR] = 1'b1; // [R9]
      end

      // transfer engine
      unique case (s.st)
         ENG_IDLE: begin
            if (tok_valid && s.attach && ep_ok) begin
               next_s.cur      = d;
               next_s.idx      = 6'h00;
               next_s.tx_ph    = 1'b0;
               next_s.is_setup = tok.pid == PID_SETUP;
               next_s.drop     = 1'b0;
               next_s.bad      = !buf_ok(s.bd_addr[d], s.bd_cnt[d]); // [R22]
               next_s.hs       = HS_ACK;
               if (tok.pid == PID_IN) begin
                  if (s.stall[tok.ep[0]]) begin
                     next_s.hs = HS_STALL; // [R8]
                     next_s.st = ENG_HS;
                  end else if (!s.bd_stat[d][`UEB_BD_OWN]) begin
                     next_s.hs = HS_NAK; // [R12]
                     next_s.st = ENG_HS;
                  end else if (!buf_ok(s.bd_addr[d], s.bd_cnt[d])) begin
                     set_f[`UEB_F_ERR] = 1'b1; // [R9]
                  end else begin
                     next_s.st = ENG_TX; // [R3]
                  end
               end else begin
                  next_s.st = ENG_RX;
                  if (tok.pid == PID_SETUP && tok.ep == 4'h0) begin
                     next_s.drop = 1'b0; // [R20]
                  end else if (s.stall[tok.ep[0]]) begin
                     next_s.drop = 1'b1; // [R8]
                     next_s.hs   = HS_STALL;
                  end else if (!s.bd_stat[d][`UEB_BD_OWN]) begin
                     next_s.drop = 1'b1; // [R10]
                     next_s.hs   = HS_NAK;
                  end
               end
            end
         end
         ENG_RX: begin
            if (rx.done) begin
               if (rx.crc_err || (s.bad && !s.drop)) begin
                  set_f[`UEB_F_ERR] = 1'b1; // [R9]
                  next_s.st = ENG_IDLE;
               end else if (s.drop) begin
                  next_s.st = ENG_HS;
               end else begin
                  // hand the filled buffer back to firmware
                  next_s.bd_cnt[s.cur] = {2'b00, s.idx};
                  next_s.bd_stat[s.cur][`UEB_BD_OWN]   = 1'b0; // [R10]
                  next_s.bd_stat[s.cur][`UEB_BD_SETUP] = s.is_setup;
                  next_s.xstat = 8'h00;
                  next_s.xstat[`UEB_XS_EP]    = s.cur[1];
                  next_s.xstat[`UEB_XS_SETUP] = s.is_setup; // [R1]
                  set_f[`UEB_F_TOK] = 1'b1; // [R1]
                  next_s.st = ENG_HS;
               end
            end else if (rx.valid && !s.drop) begin
               if ({2'b00, s.idx} < s.bd_cnt[s.cur]) begin
                  b_we       = !s.bad; // [R1]
                  next_s.idx = s.idx + 6'h01;
               end else begin
                  next_s.bad = 1'b1; // overrun counts as a bus error
               end
            end
         end
         ENG_TX: begin
            if (!s.tx_ph) begin
               next_s.tx_ph = 1'b1; // fetch cycle
            end else if (tx_ready) begin
               if (tx.last) begin
                  next_s.bd_stat[s.cur][`UEB_BD_OWN] = 1'b0; // [R12]
                  next_s.xstat = 8'h00;
                  next_s.xstat[`UEB_XS_EP]  = s.cur[1];
                  next_s.xstat[`UEB_XS_DIR] = 1'b1;
                  set_f[`UEB_F_TOK] = 1'b1; // [R3]
                  next_s.st = ENG_IDLE;
               end else begin
                  next_s.idx   = s.idx + 6'h01;
                  next_s.tx_ph = 1'b0;
               end
            end
         end
         ENG_HS: begin
            next_s.st = ENG_IDLE;
         end
      endcase

      // host bus reset aborts any transfer and ends suspend
      if (rst_edge) begin
         set_f[`UEB_F_RST] = 1'b1;
         next_s.st   = ENG_IDLE;
         next_s.susp = 1'b0;
      end

      // hardware set wins over firmware clear
      next_s.iflag = (s.iflag & ~clr_f) | set_f; // [R23]
      next_s.irq   = |(next_s.iflag & next_s.ien); // [R15]
   end

   // whole state in one register; enable low freezes everything
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s    <= '0;
         s.st <= ENG_IDLE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   ueb_dpram u_ram (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .a_addr  (ram_index(reg_req.addr)),
      .a_we    (a_we),
      .a_wdata (reg_req.wdata),
      .a_rdata (a_rdata),
      .b_addr  (b_addr),
      .b_we    (b_we),
      .b_wdata (rx.data),
      .b_rdata (b_rdata)
   );

   // outputs
   assign reg_rdata = s.rd_ram ? a_rdata : s.rdata;
   assign tx_valid  = (s.st == ENG_TX) && s.tx_ph;
   assign tx.data   = b_rdata;
   assign tx.empty  = s.bd_cnt[s.cur] == 8'h00;
   assign tx.last   = tx.empty || ({2'b00, s.idx} + 8'h01 == s.bd_cnt[s.cur]);
   assign tx.data1  = s.bd_stat[s.cur][`UEB_BD_DATA1];
   assign hs_valid  = s.st == ENG_HS;
   assign hs_code   = s.hs;
   assign pullup_en = s.attach; // [R6]
   assign suspend   = s.susp;
   assign usb_irq   = s.irq; // [R15]
endmodule

/* dv/ueb_core_properties.sv */
// port-level assertions for the endpoint buffer core
`timescale 1ns/1ps
`include "ueb_cfg.svh"
module ueb_core_properties #(
   parameter int IDLE_CYCLES = 50
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // firmware and link side
   input wire ueb_pkg::ueb_reg_req_s reg_req,
   input wire logic                  tok_valid,
   input wire ueb_pkg::ueb_tok_s     tok,
   input wire ueb_pkg::ueb_rx_s      rx,
   input wire logic                  tx_valid,
   input wire ueb_pkg::ueb_tx_s      tx,
   input wire logic                  tx_ready,
   input wire logic                  hs_valid,
   input wire ueb_pkg::ueb_hs_e      hs_code,
   // pins
   input wire logic                  line_active,
   input wire logic                  pullup_en,
   input wire logic                  suspend
);
   import ueb_pkg::*;
   logic [1:0]  stl, en;
   logic        su_pend, tk, ctrl_wr;
   logic [15:0] icnt;

   // mirrors: endpoint control, setup, idle count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stl     <= 2'h0;
         en      <= 2'h0;
         su_pend <= 1'b0;
         icnt    <= 16'h0000;
      end else begin
         if (reg_req.we && reg_req.addr[8:1] == 8'h02) begin
            stl[reg_req.addr[0]] <= reg_req.wdata[`UEB_EP_STALL];
            en[reg_req.addr[0]]  <= reg_req.wdata[`UEB_EP_EN];
         end
         if (rx.done)
            su_pend <= 1'b0;
         else if (tk && tok.pid == PID_SETUP && tok.ep == 4'h0)
            su_pend <= 1'b1;
         if (line_active)
            icnt <= 16'h0000;
         else if (icnt != 16'hFFFF)
            icnt <= icnt + 16'h0001;
      end
   end
   // tokens the core must take
   assign tk = tok_valid && pullup_en && tok.ep < 4'h2 && en[tok.ep[0]];
   assign ctrl_wr = reg_req.we && reg_req.addr == `UEB_A_CTRL;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_attach_pullup: assert property (
      ctrl_wr |-> ##2 pullup_en == $past(reg_req.wdata[0], 2))
      else $error("attach lost");
   a_no_autodetach: assert property (
      $fell(pullup_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
      else $error("auto detach");
   a_stall_refuse: assert property (
      tk && stl[tok.ep[0]] && tok.pid == PID_IN |=> hs_valid && hs_code == HS_STALL)
      else $error("stall ignored");
   a_in_answer: assert property (
      tk && !stl[tok.ep[0]] && tok.pid == PID_IN
      |=> (hs_valid && hs_code == HS_NAK) or (!hs_valid ##1 tx_valid))
      else $error("bad in answer");
   a_setup_ack: assert property (
      rx.done && !rx.crc_err && su_pend |=> hs_valid && hs_code == HS_ACK)
      else $error("setup not acked");
   a_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx))
      else $error("byte not held");
   a_idle_set: assert property (
      icnt == IDLE_CYCLES + 5 |-> suspend)
      else $error("no suspend");
   a_idle_early: assert property (
      $rose(suspend) |-> icnt >= IDLE_CYCLES)
      else $error("suspend too early");
   a_wake_up: assert property (
      suspend && $rose(line_active) |-> ##[2:5] !suspend)
      else $error("no wake");
endmodule

bind ueb_core ueb_core_properties #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (
   .clk, .rst_n, .reg_req, .tok_valid, .tok, .rx, .tx_valid, .tx, .tx_ready,
   .hs_valid, .hs_code, .line_active, .pullup_en, .suspend
);

/* dv/ueb_host_model.sv */
// host model for the core's link inputs
`timescale 1ns/1ps
module ueb_host_model (
   // clock and pace
   input  wire logic              clk,
   input  wire logic              slow,
   // toward the core
   output logic                   tok_valid,
   output ueb_pkg::ueb_tok_s      tok,
   output ueb_pkg::ueb_rx_s       rx,
   output logic                   link_err,
   output logic                   tx_ready,
   output logic                   line_active,
   output logic                   bus_reset_pin
);
   import ueb_pkg::*;
   // quiet bus, active line
   initial begin
      {tok_valid, tok, rx, link_err, bus_reset_pin} = '0;
      line_active = 1'b1;
   end
   // slow host takes a byte every other cycle
   always @(posedge clk)
      tx_ready <= slow ? !tx_ready : 1'b1;
   task automatic token(input ueb_pid_e pid, input logic [3:0] ep);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok.pid   <= pid;
      tok.ep    <= ep;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok.ep    <= ~ep;
   endtask
   // released lines show junk
   task automatic send(input logic [7:0] d, input logic last, input logic crc);
      @(posedge clk);
      rx.valid <= 1'b1;
      rx.data  <= d;
      @(posedge clk);
      rx.valid <= 1'b0;
      rx.data  <= ~d;
      if (last) begin
         rx.done    <= 1'b1;
         rx.crc_err <= crc;
         @(posedge clk);
         rx.done    <= 1'b0;
         rx.crc_err <= ~crc;
      end
   endtask
   task automatic err_pulse;
      @(posedge clk);
      link_err <= 1'b1;
      @(posedge clk);
      link_err <= 1'b0;
   endtask
   task automatic bus_reset;
      @(posedge clk);
      bus_reset_pin <= 1'b1;
      repeat (4) @(posedge clk);
      bus_reset_pin <= 1'b0;
   endtask
   task automatic line(input logic v);
      @(posedge clk);
      line_active <= v;
   endtask
endmodule

/* dv/ueb_core_tb_top.sv */
// self-checking bench for the endpoint buffer core
`timescale 1ns/1ps
`include "ueb_cfg.svh"
module ueb_core_tb_top;
   import ueb_pkg::*;
   localparam int IDLE = 50;
   logic clk = 1'b0;
   logic rst_n, ce, slow, rd_pend = 1'b0;
   ueb_reg_req_s req;
   logic [7:0] rdata;
   logic tok_valid, link_err, tx_valid, tx_ready, hs_valid, line_act, bus_rst;
   logic pullup_en, suspend, usb_irq;
   ueb_tok_s tok;
   ueb_rx_s rx;
   ueb_tx_s tx;
   ueb_hs_e hs_code;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] lf = 32'h00012F76;
   logic [7:0] q_rd[$], q_tx[$], pay[8];
   ueb_hs_e q_hs[$];

   always #25 clk = ~clk;
   ueb_core #(.IDLE_CYCLES(IDLE)) u_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(req), .reg_rdata(rdata),
      .tok_valid(tok_valid), .tok(tok), .rx(rx), .link_err(link_err),
      .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready), .hs_valid(hs_valid),
      .hs_code(hs_code), .line_active(line_act), .bus_reset_pin(bus_rst),
      .pullup_en(pullup_en), .suspend(suspend), .usb_irq(usb_irq));
   ueb_host_model u_host (
      .clk(clk), .slow(slow), .tok_valid(tok_valid), .tok(tok), .rx(rx),
      .link_err(link_err), .tx_ready(tx_ready), .line_active(line_act),
      .bus_reset_pin(bus_rst));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      req.we <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      q_rd.push_back(e);
      @(posedge clk);
      req.re <= 1'b0;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_hs(input ueb_hs_e g, input ueb_hs_e e);
      chk8(8'(g), 8'(e));
   endtask
   task automatic wrap_up;
      if (q_rd.size() + q_tx.size() + q_hs.size() != 0)
         fail_count++;
      if (fail_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // oldest note per result kind
   always @(posedge clk) rd_pend <= req.re;
   always @(negedge clk) begin
      if (rd_pend)
         chk8(rdata, q_rd.size() > 0 ? q_rd.pop_front() : 8'hXX);
      if (tx_valid && tx_ready)
         chk8(tx.data, q_tx.size() > 0 ? q_tx.pop_front() : 8'hXX);
      if (hs_valid)
         chk_hs(hs_code, q_hs.size() > 0 ? q_hs.pop_front() : ueb_hs_e'(2'h3));
   end
   // hang guard
   initial begin
      repeat (4000) @(posedge clk);
      fail_count++;
      wrap_up();
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      slow = 1'b0;
      req = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 4; a++) rd(9'(a), `UEB_RST_BYTE);
      rd(9'h100, 8'h00);
      // start-up: bus reset interrupt only
      wr(`UEB_A_IEN, 8'h08);
      u_host.bus_reset();
      rd(`UEB_A_IFLAG, 8'h08);
      chk8({7'h00, usb_irq}, 8'h01);
      wr(`UEB_A_IFLAG, 8'h08);
      wr(`UEB_A_EPCTL0, 8'h02);
      wr(9'h011, 8'h08);
      wr(9'h012, 8'hB8);
      wr(9'h010, 8'h80);
      wr(9'h016, 8'hC0);
      wr(`UEB_A_IEN, 8'h0B);
      wr(`UEB_A_CTRL, 8'h01);
      // setup with eight random bytes
      q_hs.push_back(HS_ACK);
      u_host.token(PID_SETUP, 4'h0);
      for (int i = 0; i < 8; i++) begin
         lf = nxt(lf);
         pay[i] = lf[7:0];
         u_host.send(pay[i], i == 7, 1'b0);
      end
      rd(`UEB_A_XSTAT, 8'h04);
      rd(`UEB_A_IFLAG, 8'h01);
      chk8({7'h00, usb_irq}, 8'h01);
      rd(9'h010, 8'h04);
      rd(9'h011, 8'h08);
      for (int i = 0; i < 8; i++) rd(9'h1B8 + 9'(i), pay[i]);
      wr(`UEB_A_IFLAG, 8'h01);
      rd(`UEB_A_IFLAG, 8'h00);
      // IN: NAK, then load and send slowly
      q_hs.push_back(HS_NAK);
      u_host.token(PID_IN, 4'h0);
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         pay[i] = lf[7:0];
         wr(9'h1C0 + 9'(i), pay[i]);
         q_tx.push_back(pay[i]);
      end
      wr(9'h015, 8'h04);
      wr(9'h014, 8'hC0);
      wr(9'h015, 8'h09);
      rd(9'h015, 8'h04);
      slow = 1'b1;
      u_host.token(PID_IN, 4'h0);
      for (int k = 0; k < 40 && q_tx.size() > 0; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      rd(`UEB_A_IFLAG, 8'h01);
      rd(`UEB_A_XSTAT, 8'h08);
      rd(9'h014, 8'h40);
      wr(`UEB_A_IFLAG, 8'h01);
      // stall refuses until cleared
      wr(`UEB_A_EPCTL0, 8'h03);
      q_hs.push_back(HS_STALL);
      u_host.token(PID_IN, 4'h0);
      q_hs.push_back(HS_STALL);
      u_host.token(PID_OUT, 4'h0);
      u_host.send(8'h5A, 1'b1, 1'b0);
      wr(`UEB_A_EPCTL0, 8'h02);
      q_hs.push_back(HS_NAK);
      u_host.token(PID_IN, 4'h0);
      // bus error keeps us attached
      u_host.err_pulse();
      rd(`UEB_A_IFLAG, 8'h02);
      wr(`UEB_A_IFLAG, 8'h02);
      // detached core ignores the host
      wr(`UEB_A_CTRL, 8'h00);
      u_host.token(PID_IN, 4'h0);
      repeat (4) @(posedge clk);
      wr(`UEB_A_CTRL, 8'h01);
      // idle suspends, activity wakes
      u_host.line(1'b0);
      repeat (IDLE + 8) @(posedge clk);
      rd(`UEB_A_CTRL, 8'h07);
      rd(`UEB_A_IEN, 8'h0F);
      u_host.line(1'b1);
      repeat (6) @(posedge clk);
      rd(`UEB_A_IFLAG, 8'h04);
      wr(`UEB_A_IEN, 8'h0B);
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule
